// File: logic/gpps_pkg.sv
// Purpose: constants for the eight-pin port with pin sense
// Assumes: byte offsets of the port and mirror window, 8-bit data
// Notes: offsets, field positions and sense codes shared by the port, control memory and bench
// Function
// - reset leaves drivers off, inputs on
// - pin n owns drive-enable and level bit n
// - pin level synchronised into input value
// - set/clear ports change level bits
// - flip port or input write inverts level
// - drive-enable clear port makes pin input
// - drive-enable flip port inverts direction
// - per-pin control at 0x10 plus n
// - invert select inverts readback and output
// - invert change makes a visible edge
// - weak high resistor only when not driving
// - input-disabled freezes input value bit
// - mirror window behaves as regular copies
// - peripheral override per pin aspect
// - flag on sense match, irq while set and sense on
// - avoid invert and sense change together
// - pending sense may fire after re-enable
// - sense rewrite may drop pending request
// - clock-stopped wake on any-edge or low-level
// - partial pins need one-cycle pulse
// - three-cycle dead time after interrupt
// - level event equals pin xor invert when buffer on
// - write 1 clears flag
// - sense 0 disables irq, buffer on
package gpps_pkg;
  localparam logic [5:0] OFS_DIR      = 6'h00;
  localparam logic [5:0] OFS_DIR_SET  = 6'h01;
  localparam logic [5:0] OFS_DIR_CLR  = 6'h02;
  localparam logic [5:0] OFS_DIR_FLIP = 6'h03;
  localparam logic [5:0] OFS_OUT      = 6'h04;
  localparam logic [5:0] OFS_OUT_SET  = 6'h05;
  localparam logic [5:0] OFS_OUT_CLR  = 6'h06;
  localparam logic [5:0] OFS_OUT_FLIP = 6'h07;
  localparam logic [5:0] OFS_IN       = 6'h08;
  localparam logic [5:0] OFS_FLAGS    = 6'h09;
  localparam logic [5:0] OFS_PIN_CTRL = 6'h10;
  localparam logic [5:0] OFS_MIR_DIR  = 6'h20;
  localparam logic [5:0] OFS_MIR_OUT  = 6'h21;
  localparam logic [5:0] OFS_MIR_IN   = 6'h22;
  localparam logic [5:0] OFS_MIR_FLG  = 6'h23;
  localparam int          INV_BIT     = 7;
  localparam int          PULL_BIT    = 3;
  localparam logic [7:0]  CTRL_MASK   = 8'h8F;
  localparam logic [7:0]  RST_BYTE    = 8'h00;
  localparam int          DEAD_CYC    = 3;
  typedef enum logic [2:0]
  {
    SENSE_OFF  = 3'b000,
    SENSE_ANY  = 3'b001,
    SENSE_RISE = 3'b010,
    SENSE_FALL = 3'b011,
    SENSE_NOIN = 3'b100,
    SENSE_LOW  = 3'b101
  } gpps_sense_e;
endpackage

// File: logic/gpps_ctrl_mem.sv
// Purpose: per-pin control storage with registered read
// Assumes: one write or read per cycle
// Notes: all entries also exposed in parallel for the pin logic
`timescale 1ns/1ns
`default_nettype none
module gpps_ctrl_mem #(
  parameter int PINS = 8
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst_b,
  // access
  input  wire logic              we,
  input  wire logic [2:0]        addr,
  input  wire logic [7:0]        wdata,
  output logic      [7:0]        rdata_q,
  // parallel view
  output logic      [PINS*8-1:0] all_q
);
  genvar g;
  generate
    for (g = 0; g < PINS; g++)
    begin : g_ent
      always_ff @(posedge clk or negedge rst_b)
      begin
        if (!rst_b)
          all_q[g*8 +: 8] <= gpps_pkg::RST_BYTE;
        else if (we && addr == 3'(g))
          all_q[g*8 +: 8] <= wdata & gpps_pkg::CTRL_MASK;
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      rdata_q <= gpps_pkg::RST_BYTE;
    else
      rdata_q <= all_q[addr*8 +: 8];
  end
endmodule
`default_nettype wire

// File: logic/gpps_port.sv
// Purpose: eight-pin general purpose port with pin sense and events
// Assumes: pins asynchronous to clk; override inputs from on-chip logic on clk
// Notes: read data valid the cycle after the read strobe only
`timescale 1ns/1ns
`default_nettype none
module gpps_port #(
  parameter int PINS = 8
) (
  // clock and reset
  input  wire logic            clk,
  input  wire logic            rst_b,
  // register port
  input  wire logic [5:0]      addr,
  input  wire logic [7:0]      wdata,
  input  wire logic            wr,
  input  wire logic            rd,
  output logic      [7:0]      rdata_q,
  // pins
  input  wire logic [PINS-1:0] pin_i,
  output logic      [PINS-1:0] pin_o,
  output logic      [PINS-1:0] pin_oe,
  output logic      [PINS-1:0] pull_en,
  output logic      [PINS-1:0] inbuf_en,
  // peripheral override
  input  wire logic [PINS-1:0] ovr_oe_en,
  input  wire logic [PINS-1:0] ovr_oe,
  input  wire logic [PINS-1:0] ovr_lvl_en,
  input  wire logic [PINS-1:0] ovr_lvl,
  // interrupt and wake
  output logic                 irq_q,
  output logic      [PINS-1:0] wake_q,
  // level events
  output logic      [PINS-1:0] event_q
);
  logic [PINS-1:0]   dir_q;
  logic [PINS-1:0]   out_q;
  logic [PINS-1:0]   in_q;
  logic [PINS-1:0]   flag_q;
  logic [PINS-1:0]   sync1_q;
  logic [PINS-1:0]   sync2_q;
  logic [PINS-1:0]   prev_q;
  logic [PINS-1:0]   hit;
  logic [PINS-1:0]   inv;
  logic [PINS-1:0]   noin;
  logic [PINS-1:0]   sense_on;
  logic [PINS*8-1:0] ctrl_all;
  logic              ctrl_we;
  logic [1:0]        dead_q [PINS];

  // any write inside the control block goes to the control memory
  assign ctrl_we = wr && addr[5:3] == gpps_pkg::OFS_PIN_CTRL[5:3];

  gpps_ctrl_mem #(
    .PINS    (PINS)
  ) u_ctrl (
    .clk     (clk),
    .rst_b   (rst_b),
    .we      (ctrl_we),
    .addr    (addr[2:0]),
    .wdata   (wdata),
    .rdata_q (),
    .all_q   (ctrl_all)
  );

  // drive enable
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      dir_q <= gpps_pkg::RST_BYTE;
    else if (wr)
    begin
      case (addr)
        gpps_pkg::OFS_DIR, gpps_pkg::OFS_MIR_DIR: dir_q <= wdata;
        gpps_pkg::OFS_DIR_SET:  dir_q <= dir_q | wdata;
        gpps_pkg::OFS_DIR_CLR:  dir_q <= dir_q & ~wdata;
        gpps_pkg::OFS_DIR_FLIP: dir_q <= dir_q ^ wdata;
        default:                dir_q <= dir_q;
      endcase
    end
  end

  // output level; stored as written, inversion applied at the pin
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      out_q <= gpps_pkg::RST_BYTE;
    else if (wr)
    begin
      case (addr)
        gpps_pkg::OFS_OUT, gpps_pkg::OFS_MIR_OUT: out_q <= wdata;
        gpps_pkg::OFS_OUT_SET:  out_q <= out_q | wdata;
        gpps_pkg::OFS_OUT_CLR:  out_q <= out_q & ~wdata;
        gpps_pkg::OFS_OUT_FLIP, gpps_pkg::OFS_IN, gpps_pkg::OFS_MIR_IN:
          out_q <= out_q ^ wdata;
        default:                out_q <= out_q;
      endcase
    end
  end

  genvar g;
  generate
    for (g = 0; g < PINS; g++)
    begin : g_pin
      assign inv[g]  = ctrl_all[g*8 + gpps_pkg::INV_BIT];
      assign noin[g] = ctrl_all[g*8 +: 3] == gpps_pkg::SENSE_NOIN;
      assign sense_on[g] = ctrl_all[g*8 +: 3] != gpps_pkg::SENSE_OFF
                           && !noin[g];

      // two-stage synchroniser; halts with the clock, frozen when input is off
      always_ff @(posedge clk or negedge rst_b)
      begin
        if (!rst_b)
        begin
          sync1_q[g] <= 1'b0;
          sync2_q[g] <= 1'b0;
        end
        else if (!noin[g])
        begin
          sync1_q[g] <= pin_i[g];
          sync2_q[g] <= sync1_q[g];
        end
      end

      // inverted readback; an invert change looks like a pin edge
      always_ff @(posedge clk or negedge rst_b)
      begin
        if (!rst_b)
        begin
          in_q[g]   <= 1'b0;
          prev_q[g] <= 1'b0;
        end
        else
        begin
          in_q[g]   <= noin[g] ? in_q[g] : sync2_q[g] ^ inv[g];
          prev_q[g] <= in_q[g];
        end
      end

      // sense match; pending state survives input disable (frozen in_q)
      always_comb
      begin
        case (gpps_pkg::gpps_sense_e'(ctrl_all[g*8 +: 3]))
          gpps_pkg::SENSE_ANY:  hit[g] = in_q[g] != prev_q[g];
          gpps_pkg::SENSE_RISE: hit[g] = in_q[g] && !prev_q[g];
          gpps_pkg::SENSE_FALL: hit[g] = !in_q[g] && prev_q[g];
          gpps_pkg::SENSE_LOW:  hit[g] = !in_q[g];
          default:              hit[g] = 1'b0;
        endcase
      end

      // dead time after each raised interrupt
      always_ff @(posedge clk or negedge rst_b)
      begin
        if (!rst_b)
          dead_q[g] <= 2'd0;
        else if (hit[g] && dead_q[g] == 2'd0)
          dead_q[g] <= 2'(gpps_pkg::DEAD_CYC);
        else if (dead_q[g] != 2'd0)
          dead_q[g] <= dead_q[g] - 2'd1;
      end

      // flag: set wins over the software clear
      always_ff @(posedge clk or negedge rst_b)
      begin
        if (!rst_b)
          flag_q[g] <= 1'b0;
        else if (hit[g] && dead_q[g] == 2'd0)
          flag_q[g] <= 1'b1;
        else if (wr && wdata[g] && (addr == gpps_pkg::OFS_FLAGS
                                    || addr == gpps_pkg::OFS_MIR_FLG))
          flag_q[g] <= 1'b0;
      end

      // wake: any-edge and low-level are the clock-free choices
      always_ff @(posedge clk or negedge rst_b)
      begin
        if (!rst_b)
          wake_q[g] <= 1'b0;
        else
          wake_q[g] <= ctrl_all[g*8 +: 3] == gpps_pkg::SENSE_ANY
                       || ctrl_all[g*8 +: 3] == gpps_pkg::SENSE_LOW;
      end

      // pin drive with per-aspect override
      always_ff @(posedge clk or negedge rst_b)
      begin
        if (!rst_b)
        begin
          pin_oe[g]   <= 1'b0;
          pin_o[g]    <= 1'b0;
          pull_en[g]  <= 1'b0;
          inbuf_en[g] <= 1'b1;
          event_q[g]  <= 1'b0;
        end
        else
        begin
          pin_oe[g]   <= ovr_oe_en[g] ? ovr_oe[g] : dir_q[g];
          pin_o[g]    <= ovr_lvl_en[g] ? ovr_lvl[g] : out_q[g] ^ inv[g];
          pull_en[g]  <= ctrl_all[g*8 + gpps_pkg::PULL_BIT]
                         && !(ovr_oe_en[g] ? ovr_oe[g] : dir_q[g]);
          inbuf_en[g] <= !noin[g];
          event_q[g]  <= noin[g] ? 1'b0 : sync2_q[g] ^ inv[g];
        end
      end

      a_flag_clear: assert property (@(posedge clk) disable iff (!rst_b)
        $past(flag_q[g]) && !$past(hit[g]) && $past(wr) && $past(wdata[g])
        && $past(addr) == gpps_pkg::OFS_FLAGS |-> !flag_q[g])
        else $error("flag not cleared by write one");
      a_dead_time: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(flag_q[g]) |-> dead_q[g] == 2'd3)
        else $error("dead time not armed");
      a_pull_off: assert property (@(posedge clk) disable iff (!rst_b)
        pin_oe[g] |-> !pull_en[g])
        else $error("pull active while driving");
      a_event_off: assert property (@(posedge clk) disable iff (!rst_b)
        !inbuf_en[g] |-> !event_q[g])
        else $error("event high with buffer off");
      a_in_frozen: assert property (@(posedge clk) disable iff (!rst_b)
        noin[g] && $past(noin[g]) |-> $stable(in_q[g]))
        else $error("input value moved while disabled");
      a_sync_hold: assert property (@(posedge clk) disable iff (!rst_b)
        noin[g] |=> $stable(sync2_q[g]))
        else $error("synchroniser ran while input disabled");
      a_inbuf_off: assert property (@(posedge clk) disable iff (!rst_b)
        noin[g] |=> !inbuf_en[g])
        else $error("input buffer left on");
      a_dead_hold: assert property (@(posedge clk) disable iff (!rst_b)
        dead_q[g] != 2'h0 |=> !$rose(flag_q[g]))
        else $error("flag rose inside dead time");
      a_flag_set: assert property (@(posedge clk) disable iff (!rst_b)
        hit[g] && dead_q[g] == 2'h0 |=> flag_q[g])
        else $error("sense match did not set flag");
      a_flag_keep: assert property (@(posedge clk) disable iff (!rst_b)
        flag_q[g] && !(wr && wdata[g] && (addr == gpps_pkg::OFS_FLAGS
        || addr == gpps_pkg::OFS_MIR_FLG)) |=> flag_q[g])
        else $error("flag lost without write one");
      a_mir_clear: assert property (@(posedge clk) disable iff (!rst_b)
        wr && wdata[g] && addr == gpps_pkg::OFS_MIR_FLG && !hit[g] |=> !flag_q[g])
        else $error("mirror flag clear failed");
      a_pin_drive: assert property (@(posedge clk) disable iff (!rst_b)
        !ovr_oe_en[g] |=> pin_oe[g] == $past(dir_q[g]))
        else $error("pin drive does not follow drive enable");
      a_ovr_drive: assert property (@(posedge clk) disable iff (!rst_b)
        ovr_oe_en[g] |=> pin_oe[g] == $past(ovr_oe[g]))
        else $error("override drive not applied");
      a_pin_level: assert property (@(posedge clk) disable iff (!rst_b)
        !ovr_lvl_en[g] |=> pin_o[g] == ($past(out_q[g]) ^ $past(inv[g])))
        else $error("pin level not stored level with invert");
      a_pull_on: assert property (@(posedge clk) disable iff (!rst_b)
        ctrl_all[g*8 + gpps_pkg::PULL_BIT] && !ovr_oe_en[g] && !dir_q[g] |=> pull_en[g])
        else $error("pull missing on undriven pin");
      a_event_level: assert property (@(posedge clk) disable iff (!rst_b)
        !noin[g] |=> event_q[g] == ($past(sync2_q[g]) ^ $past(inv[g])))
        else $error("event does not follow pin");
      a_sense_off: assert property (@(posedge clk) disable iff (!rst_b)
        ctrl_all[g*8 +: 3] == gpps_pkg::SENSE_OFF |-> !hit[g])
        else $error("match with sense off");
      a_wake_low: assert property (@(posedge clk) disable iff (!rst_b)
        ctrl_all[g*8 +: 3] == gpps_pkg::SENSE_LOW |=> wake_q[g])
        else $error("low level sense not marked for wake");
      a_wake_rise: assert property (@(posedge clk) disable iff (!rst_b)
        ctrl_all[g*8 +: 3] == gpps_pkg::SENSE_RISE |=> !wake_q[g])
        else $error("rising sense marked for wake");
    end
  endgenerate

  // irq only while an enabled pin's flag is set
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      irq_q <= 1'b0;
    else
      irq_q <= |(flag_q & sense_on);
  end

  // read data straight from one flop; zero outside the cycle after a read
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      rdata_q <= gpps_pkg::RST_BYTE;
    else if (!rd)
      rdata_q <= 8'h00;
    else
    begin
      case (addr)
        gpps_pkg::OFS_DIR, gpps_pkg::OFS_DIR_SET, gpps_pkg::OFS_DIR_CLR,
        gpps_pkg::OFS_DIR_FLIP, gpps_pkg::OFS_MIR_DIR: rdata_q <= dir_q;
        gpps_pkg::OFS_OUT, gpps_pkg::OFS_OUT_SET, gpps_pkg::OFS_OUT_CLR,
        gpps_pkg::OFS_OUT_FLIP, gpps_pkg::OFS_MIR_OUT: rdata_q <= out_q;
        gpps_pkg::OFS_IN, gpps_pkg::OFS_MIR_IN:   rdata_q <= in_q;
        gpps_pkg::OFS_FLAGS, gpps_pkg::OFS_MIR_FLG: rdata_q <= flag_q;
        // control bytes come from the parallel view, so no second read stage
        default:
          rdata_q <= addr[5:3] == gpps_pkg::OFS_PIN_CTRL[5:3]
                     ? ctrl_all[addr[2:0]*8 +: 8] : 8'h00;
      endcase
    end
  end

  a_dir_clear: assert property (@(posedge clk) disable iff (!rst_b)
    wr && addr == gpps_pkg::OFS_DIR_CLR && wdata[0] |=> !dir_q[0] ##1 !pin_oe[0]
    || ovr_oe_en[0])
    else $error("drive enable clear failed");
  a_irq_flag: assert property (@(posedge clk) disable iff (!rst_b)
    |(flag_q & sense_on) |=> irq_q)
    else $error("irq not raised for set flag");
  a_out_flip: assert property (@(posedge clk) disable iff (!rst_b)
    wr && addr == gpps_pkg::OFS_IN |=> out_q == ($past(out_q) ^ $past(wdata)))
    else $error("input write did not flip level");

  // irq low without an enabled flag; register port effects, one cycle after the strobe
  a_irq_low: assert property (@(posedge clk) disable iff (!rst_b)
    !(|(flag_q & sense_on)) |=> !irq_q)
    else $error("irq raised without enabled flag");
  a_dir_wr: assert property (@(posedge clk) disable iff (!rst_b)
    wr && addr == gpps_pkg::OFS_DIR |=> dir_q == $past(wdata))
    else $error("drive enable write lost");
  a_dir_set: assert property (@(posedge clk) disable iff (!rst_b)
    wr && addr == gpps_pkg::OFS_DIR_SET |=> dir_q == ($past(dir_q) | $past(wdata)))
    else $error("drive enable set failed");
  a_dir_flip: assert property (@(posedge clk) disable iff (!rst_b)
    wr && addr == gpps_pkg::OFS_DIR_FLIP |=> dir_q == ($past(dir_q) ^ $past(wdata)))
    else $error("drive enable flip failed");
  a_out_set: assert property (@(posedge clk) disable iff (!rst_b)
    wr && addr == gpps_pkg::OFS_OUT_SET |=> out_q == ($past(out_q) | $past(wdata)))
    else $error("level set failed");
  a_out_clr: assert property (@(posedge clk) disable iff (!rst_b)
    wr && addr == gpps_pkg::OFS_OUT_CLR |=> out_q == ($past(out_q) & ~$past(wdata)))
    else $error("level clear failed");
  a_rd_dir: assert property (@(posedge clk) disable iff (!rst_b)
    rd && addr == gpps_pkg::OFS_MIR_DIR |=> rdata_q == $past(dir_q))
    else $error("mirror drive enable read wrong");
  a_rd_out: assert property (@(posedge clk) disable iff (!rst_b)
    rd && addr == gpps_pkg::OFS_OUT |=> rdata_q == $past(out_q))
    else $error("level read wrong");
  a_rd_in: assert property (@(posedge clk) disable iff (!rst_b)
    rd && addr == gpps_pkg::OFS_MIR_IN |=> rdata_q == $past(in_q))
    else $error("mirror input read wrong");
  a_rd_flags: assert property (@(posedge clk) disable iff (!rst_b)
    rd && addr == gpps_pkg::OFS_FLAGS |=> rdata_q == $past(flag_q))
    else $error("flag read wrong");
  a_rd_ctrl: assert property (@(posedge clk) disable iff (!rst_b)
    rd && addr == gpps_pkg::OFS_PIN_CTRL |=> rdata_q == $past(ctrl_all[7:0]))
    else $error("control read wrong");
endmodule
`default_nettype wire

// File: test/gpps_pin_model.sv
// Purpose: pin-side model, resolving each pad from port drive, pull and an outside source
// Assumes: the outside source only drives where ext_drv is high
// Notes: a floating, unpulled pad toggles every cycle so a stale level never looks valid
`timescale 1ns/1ns
`default_nettype none
module gpps_pin_model (
  // clock
  input  wire logic       clk,
  // port side
  input  wire logic [7:0] pin_o,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] pull_en,
  // outside source
  input  wire logic [7:0] ext_lvl,
  input  wire logic [7:0] ext_drv,
  // resolved pad
  output logic      [7:0] pin_lvl
);
  logic [7:0] float_q = 8'h55;
  always_ff @(posedge clk)
  begin
    float_q <= ~float_q;
  end
  // port driver wins, then the outside source, then the pull
  assign pin_lvl = (pin_oe & pin_o) | (~pin_oe & ext_drv & ext_lvl)
                 | (~pin_oe & ~ext_drv & (pull_en | float_q));
endmodule
`default_nettype wire

// File: test/gpps_port_test.sv
// Purpose: register-level bench for the eight-pin port
// Assumes: read data sampled in the cycle after the strobe
// Notes: invert and sense are always written separately, never in one write
`timescale 1ns/1ns
`default_nettype none
module gpps_port_test;
  logic       clk = 1'b0;
  logic       rst_b = 1'b0;
  logic [5:0] addr = 6'h00;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic [7:0] rdata_q, pin_o, pin_oe, pull_en, inbuf_en, wake_q, event_q, pin_lvl;
  logic       irq_q;
  logic [7:0] ext_lvl = 8'h00;
  logic [7:0] ext_drv = 8'hFF;
  logic [7:0] oe_en = 8'h00;
  logic [7:0] lv_en = 8'h00;
  int         error_cnt = 0;
  int         num_checks = 0;
  always #25 clk = ~clk;
  gpps_port dut_u (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata_q(rdata_q), .pin_i(pin_lvl), .pin_o(pin_o), .pin_oe(pin_oe), .pull_en(pull_en),
    .inbuf_en(inbuf_en), .ovr_oe_en(oe_en), .ovr_oe(oe_en), .ovr_lvl_en(lv_en),
    .ovr_lvl(lv_en), .irq_q(irq_q), .wake_q(wake_q), .event_q(event_q));
  gpps_pin_model pin_u (.clk(clk), .pin_o(pin_o), .pin_oe(pin_oe), .pull_en(pull_en),
    .ext_lvl(ext_lvl), .ext_drv(ext_drv), .pin_lvl(pin_lvl));
  task stop_test;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task chk8(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  task wr_reg(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rd_chk(input logic [5:0] a, input logic [7:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk8(rdata_q, exp);
  endtask
  // one sense code on pin 4: level before, level after, flag expected
  task sense_run(input logic [2:0] code, input logic pre, input logic post, input logic e);
    @(posedge clk);
    ext_lvl[4] <= pre;
    idle(6);
    wr_reg(6'h14, {5'h00, code});
    idle(6);
    wr_reg(gpps_pkg::OFS_FLAGS, 8'hFF);
    @(posedge clk);
    ext_lvl[4] <= post;
    idle(6);
    @(posedge clk);
    rd <= 1'b1;
    addr <= gpps_pkg::OFS_FLAGS;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk8(rdata_q & 8'h10, {3'h0, e, 4'h0});
    chk8({7'h00, irq_q}, {7'h00, e});
    chk8({7'h00, wake_q[4]}, {7'h00, code == 3'h1 || code == 3'h5});
    wr_reg(gpps_pkg::OFS_MIR_FLG, 8'h10);
    wr_reg(6'h14, 8'h00);
  endtask
  initial
  begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    $display("Error at %0t: timeout", $time);
    stop_test;
  end
  initial
  begin
    idle(10);
    rst_b <= 1'b1;
    chk8(pin_oe, 8'h00);
    chk8(inbuf_en, 8'hFF);
    rd_chk(gpps_pkg::OFS_DIR, 8'h00);
    rd_chk(6'h0A, 8'h00);
    wr_reg(gpps_pkg::OFS_DIR_SET, 8'h0F);
    wr_reg(gpps_pkg::OFS_DIR_CLR, 8'h03);
    wr_reg(gpps_pkg::OFS_DIR_FLIP, 8'h81);
    rd_chk(gpps_pkg::OFS_MIR_DIR, 8'h8D);
    chk8(pin_oe, 8'h8D);
    wr_reg(gpps_pkg::OFS_OUT_SET, 8'hA0);
    wr_reg(gpps_pkg::OFS_OUT_CLR, 8'h20);
    wr_reg(gpps_pkg::OFS_OUT_FLIP, 8'h05);
    wr_reg(gpps_pkg::OFS_IN, 8'h80);
    rd_chk(gpps_pkg::OFS_OUT, 8'h05);
    rd_chk(gpps_pkg::OFS_MIR_OUT, 8'h05);
    chk8(pin_o & pin_oe, 8'h05);
    wr_reg(gpps_pkg::OFS_DIR, 8'h00);
    ext_lvl <= 8'h3C;
    idle(6);
    rd_chk(gpps_pkg::OFS_MIR_IN, 8'h3C);
    chk8(event_q, 8'h3C);
    wr_reg(gpps_pkg::OFS_PIN_CTRL, 8'h80);
    rd_chk(gpps_pkg::OFS_PIN_CTRL, 8'h80);
    idle(6);
    rd_chk(gpps_pkg::OFS_IN, 8'h3D);
    chk8(event_q, 8'h3D);
    wr_reg(gpps_pkg::OFS_DIR_SET, 8'h01);
    idle(2);
    chk8(pin_o & 8'h01, 8'h00);
    wr_reg(gpps_pkg::OFS_DIR_CLR, 8'h01);
    wr_reg(6'h12, 8'h04);
    ext_lvl <= 8'h00;
    idle(6);
    rd_chk(gpps_pkg::OFS_IN, 8'h05);
    chk8(inbuf_en, 8'hFB);
    chk8(event_q, 8'h01);
    wr_reg(6'h13, 8'h08);
    ext_drv <= 8'hF7;
    idle(3);
    chk8(pull_en, 8'h08);
    wr_reg(gpps_pkg::OFS_DIR_SET, 8'h08);
    idle(3);
    chk8(pull_en, 8'h00);
    oe_en <= 8'h40;
    lv_en <= 8'h40;
    idle(3);
    chk8(pin_oe, 8'h48);
    chk8(pin_o & 8'h40, 8'h40);
    oe_en <= 8'h00;
    lv_en <= 8'h00;
    wr_reg(gpps_pkg::OFS_DIR_CLR, 8'h08);
    sense_run(3'h1, 1'b0, 1'b1, 1'b1);
    sense_run(3'h2, 1'b1, 1'b0, 1'b0);
    sense_run(3'h3, 1'b1, 1'b0, 1'b1);
    sense_run(3'h5, 1'b1, 1'b0, 1'b1);
    sense_run(3'h0, 1'b0, 1'b1, 1'b0);
    stop_test;
  end
endmodule
`default_nettype wire
